// file: logic/scl_loader.sv
// Serial configuration loader: mode decode, clearing, bit loading and chain forwarding
`timescale 1ns/1ps
`include "scl_params.svh"

// Summary of operation
// [RULE1] Mode codes 000 and 100 select master serial with the clock driven out.
// [RULE2] Mode codes 111 and 011 select slave serial with the clock taken in.
// [RULE3] Top mode bit low enables user-pin pull-ups before configuration; high floats them.
// [RULE4] The test access port path stays enabled whatever the mode pins read.
// [RULE5] Boundary-scan code disables serial and byte-parallel loading.
// [RULE6] Unconnected mode pins read high, so slave serial is the default.
// [RULE7] Slave source sets data before each rising clock; device samples on it.
// [RULE8] After own loading, further serial bits are forwarded to the serial output.
// [RULE9] Serial output changes on the rising configuration clock in both serial modes.
// [RULE10] The source waits until every chained init pin reads high before shifting.
// [RULE11] Master mode makes the clock internally and samples data on each rise.
// [RULE12] Master clock starts near 2.5 MHz, then moves to the loaded rate.
// [RULE13] A zero rate setting means 4 MHz.
// [RULE14] The master clock rate may only rise, never fall.
// [RULE15] A selected rate above 60 MHz is held at 60 MHz.
// [RULE16] PROM reset follows init and PROM enable follows the complete pin.
// [RULE17] Restart high starts clearing, a final pass, then releases init.
// [RULE18] Loaded data is CRC checked; an error drives init low.
// [RULE19] Without CRC error, loading ends in start-up with the complete pin high.
// [RULE20] Own loading ends after a fixed total bit count for the device size.
// [RULE21] Mode codes 101 and 001 select boundary-scan configuration.
// [RULE22] Init is held low while clearing; an outside low delays loading.
// [RULE23] Forwarding starts with the first bit after the last own bit.
module scl_loader #(
  parameter int BIT_TOTAL = `SCL_BIT_TOTAL,
  parameter int CLEAR_CYC = `SCL_CLEAR_CYC,
  parameter int FINAL_CYC = `SCL_FINAL_CYC,
  parameter int CNT_W     = 24
) (
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  input  wire logic MODE_SEL_HI,
  input  wire logic MODE_SEL_MID,
  input  wire logic MODE_SEL_LO,
  input  wire logic RESTART,
  input  wire logic INIT_I,
  output logic      INIT_O,
  output logic      INIT_OE,
  input  wire logic CONFIG_CLOCK_I,
  output logic      CONFIG_CLOCK_O,
  output logic      CONFIG_CLOCK_OE,
  input  wire logic SERIAL_DIN,
  output logic      SERIAL_DOUT,
  output logic      DONE,
  output logic      PULLUP_EN,
  output logic      MODE_PIN_PULLUP,
  output logic      TAP_CONFIG_EN,
  output logic      SERIAL_LOAD_EN,
  output logic      BYTE_PARALLEL_EN
);

  localparam logic [CNT_W-1:0] SYNC_END  = CNT_W'(`SCL_SYNC_W);
  localparam logic [CNT_W-1:0] RATE_LAST = CNT_W'(`SCL_SYNC_W + `SCL_RATE_W - 1);
  localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(BIT_TOTAL - 1);
  localparam logic [7:0]       SLOW_HALF =
    8'((`SCL_SYS_KHZ + 2 * `SCL_SLOW_KHZ - 1) / (2 * `SCL_SLOW_KHZ));
  localparam logic [15:0]      CLEAR_LAST = 16'(CLEAR_CYC - 1);
  localparam logic [15:0]      FINAL_LAST = 16'(FINAL_CYC - 1);

  // System clock domain
  logic [5:0]          sys_sync_q;
  logic [2:0]          mode_pins;
  logic                restart_s;
  logic                init_s;
  logic                ok_s;
  logic                bad_s;
  logic                rate_ok_s;
  scl_pkg::scl_state_t state_reg;
  scl_pkg::scl_state_t state_next;
  scl_pkg::scl_mode_t  mode_reg;
  scl_pkg::scl_mode_t  mode_next;
  logic                pull_reg;
  logic                pull_next;
  logic [15:0]         tcnt_reg;
  logic [15:0]         tcnt_next;
  logic [7:0]          half_reg;
  logic [7:0]          half_next;
  logic                rate_seen_reg;
  logic                rate_seen_next;
  logic                done_reg;
  logic                done_next;
  logic                load_en_reg;
  logic                load_en_next;
  logic [7:0]          rate_mhz;
  logic [8:0]          rate_dbl;
  logic [7:0]          rate_half;

  // Link clock domain
  logic                load_en_l;
  logic                found_reg;
  logic                found_next;
  logic                fin_reg;
  logic                fin_next;
  logic [`SCL_SYNC_W-1:0] sync_sr_reg;
  logic [`SCL_SYNC_W-1:0] sync_sr_next;
  logic [CNT_W-1:0]    bit_cnt_reg;
  logic [CNT_W-1:0]    bit_cnt_next;
  logic [`SCL_CRC_W-1:0] crc_reg;
  logic [`SCL_CRC_W-1:0] crc_next;
  logic [`SCL_RATE_W-1:0] rate_sr_reg;
  logic [`SCL_RATE_W-1:0] rate_sr_next;
  logic                rate_ok_reg;
  logic                rate_ok_next;
  logic                ok_reg;
  logic                ok_next;
  logic                bad_reg;
  logic                bad_next;
  logic                dout_reg;
  logic                dout_next;

  scl_div_if div_if ();
  scl_sync #(.W (6)) u_sys_sync (
    .clk (CLK_SYS),
    .d   ({MODE_SEL_HI, MODE_SEL_MID, MODE_SEL_LO, RESTART, INIT_I, ok_reg}),
    .q   (sys_sync_q)
  );
  scl_sync #(.W (2)) u_sys_sync2 (
    .clk (CLK_SYS),
    .d   ({bad_reg, rate_ok_reg}),
    .q   ({bad_s, rate_ok_s})
  );
  scl_sync #(.W (1)) u_link_sync (
    .clk (CONFIG_CLOCK_I),
    .d   (load_en_reg),
    .q   (load_en_l)
  );
  scl_clk_div u_div (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .div   (div_if)
  );
  assign mode_pins = sys_sync_q[5:3];
  assign restart_s = sys_sync_q[2];
  assign init_s    = sys_sync_q[1];
  assign ok_s      = sys_sync_q[0];
  // Rate setting is stable in the link domain while its flag is high
  always_comb begin
    rate_mhz = rate_sr_reg;
    if (rate_mhz == 8'h00) begin
      rate_mhz = `SCL_DEF_RATE_MHZ;  // [RULE13]
    end
    if (rate_mhz > `SCL_MAX_RATE_MHZ) begin
      rate_mhz = `SCL_MAX_RATE_MHZ;  // [RULE15]
    end
    rate_dbl  = {rate_mhz, 1'b0};
    rate_half = 8'((9'(`SCL_SYS_MHZ) + rate_dbl - 9'h001) / rate_dbl);
  end
  always_comb begin
    state_next     = state_reg;
    mode_next      = mode_reg;
    pull_next      = pull_reg;
    tcnt_next      = tcnt_reg;
    half_next      = half_reg;
    rate_seen_next = rate_seen_reg;
    done_next      = 1'b0;
    load_en_next   = 1'b0;
    if (state_reg inside {scl_pkg::ST_RESET, scl_pkg::ST_CLEAR, scl_pkg::ST_FINAL,
                          scl_pkg::ST_WAIT}) begin
      pull_next = ~mode_pins[2];  // [RULE3]
      case (mode_pins)
        `SCL_MODE_MASTER_NOPULL, `SCL_MODE_MASTER_PULL: mode_next = scl_pkg::MD_MASTER; // [RULE1]
        `SCL_MODE_SLAVE_NOPULL, `SCL_MODE_SLAVE_PULL:   mode_next = scl_pkg::MD_SLAVE;  // [RULE2]
        `SCL_MODE_BSCAN_NOPULL, `SCL_MODE_BSCAN_PULL:   mode_next = scl_pkg::MD_BSCAN;  // [RULE21]
        default:                                        mode_next = scl_pkg::MD_BYTE;
      endcase
    end
    case (state_reg)
      scl_pkg::ST_RESET: begin
        tcnt_next = 16'h0000;
        half_next = SLOW_HALF;  // [RULE12]
        rate_seen_next = 1'b0;
        if (restart_s) begin
          state_next = scl_pkg::ST_CLEAR;  // [RULE17]
        end
      end
      scl_pkg::ST_CLEAR: begin
        tcnt_next = tcnt_reg + 16'h0001;
        if (tcnt_reg == CLEAR_LAST) begin
          tcnt_next  = 16'h0000;
          state_next = scl_pkg::ST_FINAL;  // [RULE17]
        end
      end
      scl_pkg::ST_FINAL: begin
        tcnt_next = tcnt_reg + 16'h0001;
        if (tcnt_reg == FINAL_LAST) begin
          state_next = scl_pkg::ST_WAIT;  // [RULE17]
        end
      end
      scl_pkg::ST_WAIT: begin
        if (init_s) begin  // [RULE22]
          if (mode_next == scl_pkg::MD_MASTER || mode_next == scl_pkg::MD_SLAVE) begin
            state_next = scl_pkg::ST_LOAD;
          end else begin
            state_next = scl_pkg::ST_PASS;  // [RULE5]
          end
        end
      end
      scl_pkg::ST_LOAD: begin
        load_en_next = 1'b1;
        if (rate_ok_s && !rate_seen_reg) begin
          rate_seen_next = 1'b1;
          if (mode_reg == scl_pkg::MD_MASTER && rate_half < half_reg) begin
            half_next = rate_half;  // [RULE12] [RULE14]
          end
        end
        if (bad_s) begin
          state_next = scl_pkg::ST_ERROR;  // [RULE18]
        end else if (ok_s) begin
          state_next = scl_pkg::ST_START;  // [RULE19]
          done_next  = 1'b1;
        end
      end
      scl_pkg::ST_START: begin
        load_en_next = 1'b1;
        done_next    = 1'b1;  // [RULE19]
      end
      scl_pkg::ST_ERROR: begin
        load_en_next = 1'b1;
      end
      scl_pkg::ST_PASS: begin
        state_next = scl_pkg::ST_PASS;
      end
      default: begin
        state_next = scl_pkg::ST_RESET;
      end
    endcase
    if (!restart_s) begin
      state_next   = scl_pkg::ST_RESET;
      done_next    = 1'b0;
      load_en_next = 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state_reg     <= scl_pkg::ST_RESET;
      mode_reg      <= scl_pkg::MD_SLAVE;  // [RULE6]
      pull_reg      <= 1'b0;
      tcnt_reg      <= 16'h0000;
      half_reg      <= SLOW_HALF;
      rate_seen_reg <= 1'b0;
      done_reg      <= 1'b0;
      load_en_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      mode_reg      <= mode_next;
      pull_reg      <= pull_next;
      tcnt_reg      <= tcnt_next;
      half_reg      <= half_next;
      rate_seen_reg <= rate_seen_next;
      done_reg      <= done_next;
      load_en_reg   <= load_en_next;
    end
  end
  // Master clock runs from clearing onward so the link logic is cleared too
  assign div_if.run  = (mode_reg == scl_pkg::MD_MASTER) &&
                       (state_reg != scl_pkg::ST_RESET);  // [RULE11]
  assign div_if.half = half_reg;
  // Link logic, clocked by the pad level of the configuration clock
  always_comb begin
    found_next   = found_reg;
    fin_next     = fin_reg;
    sync_sr_next = sync_sr_reg;
    bit_cnt_next = bit_cnt_reg;
    crc_next     = crc_reg;
    rate_sr_next = rate_sr_reg;
    rate_ok_next = rate_ok_reg;
    ok_next      = ok_reg;
    bad_next     = bad_reg;
    dout_next    = dout_reg;
    if (!load_en_l) begin
      found_next   = 1'b0;
      fin_next     = 1'b0;
      sync_sr_next = '0;
      bit_cnt_next = '0;
      crc_next     = '0;
      rate_sr_next = '0;
      rate_ok_next = 1'b0;
      ok_next      = 1'b0;
      bad_next     = 1'b0;
      dout_next    = 1'b1;
    end else if (!found_reg) begin
      sync_sr_next = {sync_sr_reg[`SCL_SYNC_W-2:0], SERIAL_DIN};  // [RULE7] [RULE11]
      if (sync_sr_next == `SCL_SYNC_WORD) begin
        found_next   = 1'b1;
        bit_cnt_next = SYNC_END;
      end
    end else if (!fin_reg) begin
      bit_cnt_next = bit_cnt_reg + 1'b1;
      crc_next     = {crc_reg[`SCL_CRC_W-2:0], 1'b0} ^
                     ((crc_reg[`SCL_CRC_W-1] ^ SERIAL_DIN) ? `SCL_CRC_POLY : 16'h0000);
      if (bit_cnt_reg <= RATE_LAST) begin
        rate_sr_next = {rate_sr_reg[`SCL_RATE_W-2:0], SERIAL_DIN};
        rate_ok_next = (bit_cnt_reg == RATE_LAST);
      end
      if (bit_cnt_reg == LAST_BIT) begin  // [RULE20]
        fin_next = 1'b1;
        ok_next  = (crc_next == 16'h0000);
        bad_next = (crc_next != 16'h0000);  // [RULE18]
      end
    end else begin
      dout_next = SERIAL_DIN;  // [RULE8] [RULE9] [RULE23]
    end
  end
  always_ff @(posedge CONFIG_CLOCK_I) begin
    found_reg   <= found_next;
    fin_reg     <= fin_next;
    sync_sr_reg <= sync_sr_next;
    bit_cnt_reg <= bit_cnt_next;
    crc_reg     <= crc_next;
    rate_sr_reg <= rate_sr_next;
    rate_ok_reg <= rate_ok_next;
    ok_reg      <= ok_next;
    bad_reg     <= bad_next;
    dout_reg    <= dout_next;
  end
  // Init is open drain: driven low in reset, while clearing or on error
  assign INIT_O  = 1'b0;
  assign INIT_OE = (state_reg == scl_pkg::ST_RESET) || (state_reg == scl_pkg::ST_CLEAR) ||
                   (state_reg == scl_pkg::ST_FINAL) || (state_reg == scl_pkg::ST_ERROR); // [RULE22] [RULE18]
  assign CONFIG_CLOCK_O   = div_if.clk_out;
  assign CONFIG_CLOCK_OE  = (mode_reg == scl_pkg::MD_MASTER);  // [RULE1]
  assign SERIAL_DOUT      = dout_reg;
  assign DONE             = done_reg;  // [RULE16]
  assign PULLUP_EN        = pull_reg && !done_reg;
  assign MODE_PIN_PULLUP  = 1'b1;  // [RULE6]
  assign TAP_CONFIG_EN    = 1'b1;  // [RULE4]
  assign SERIAL_LOAD_EN   = load_en_reg;
  assign BYTE_PARALLEL_EN = (mode_reg == scl_pkg::MD_BYTE) &&
                            (state_reg == scl_pkg::ST_PASS);  // [RULE5]

endmodule

// file: logic/scl_params.svh
// Constants for the serial configuration loader
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// Mode-select codes {hi, mid, lo}
`define SCL_MODE_MASTER_NOPULL 3'h4
`define SCL_MODE_MASTER_PULL   3'h0
`define SCL_MODE_SLAVE_NOPULL  3'h7
`define SCL_MODE_SLAVE_PULL    3'h3
`define SCL_MODE_BSCAN_NOPULL  3'h5
`define SCL_MODE_BSCAN_PULL    3'h1
`define SCL_MODE_BYTE_NOPULL   3'h6
`define SCL_MODE_BYTE_PULL     3'h2

// Clock rates
`define SCL_SYS_KHZ            10000
`define SCL_SLOW_KHZ           2500
`define SCL_SYS_MHZ            10
`define SCL_DEF_RATE_MHZ       8'h04
`define SCL_MAX_RATE_MHZ       8'h3c

// Bitstream layout
`define SCL_SYNC_WORD          32'h5a3cc3a5
`define SCL_SYNC_W             32
`define SCL_RATE_W             8
`define SCL_CRC_W              16
`define SCL_CRC_POLY           16'h1021
`define SCL_BIT_TOTAL          3430400

// Memory clearing timing in system clock cycles
`define SCL_CLEAR_CYC          64
`define SCL_FINAL_CYC          16

`endif

// file: logic/scl_pkg.sv
// Types for the serial configuration loader
package scl_pkg;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_CLEAR = 3'h1,
    ST_FINAL = 3'h3,
    ST_WAIT  = 3'h2,
    ST_LOAD  = 3'h6,
    ST_START = 3'h7,
    ST_ERROR = 3'h5,
    ST_PASS  = 3'h4
  } scl_state_t;

  typedef enum logic [1:0] {
    MD_MASTER = 2'h0,
    MD_SLAVE  = 2'h1,
    MD_BSCAN  = 2'h2,
    MD_BYTE   = 2'h3
  } scl_mode_t;

endpackage

// file: logic/scl_div_if.sv
// Control and output of the master configuration clock divider
`timescale 1ns/1ps
interface scl_div_if;
  logic       run;
  logic [7:0] half;
  logic       clk_out;

  modport gen  (input run, input half, output clk_out);
  modport user (output run, output half, input clk_out);
endinterface

// file: logic/scl_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module scl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q_reg    <= q_next;
  end

  assign q = q_reg;
endmodule

// file: logic/scl_clk_div.sv
// Divider making the master configuration clock from the system clock
`timescale 1ns/1ps
module scl_clk_div (
  input  wire logic clk,
  input  wire logic rst_n,
  scl_div_if.gen    div
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       clk_reg;
  logic       clk_next;

  always_comb begin
    cnt_next = cnt_reg;
    clk_next = clk_reg;
    if (!div.run) begin
      cnt_next = 8'h00;
      clk_next = 1'b0;
    end else if (cnt_reg + 8'h01 >= div.half) begin
      cnt_next = 8'h00;
      clk_next = ~clk_reg;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end

  assign div.clk_out = clk_reg;
endmodule

// file: test/scl_loader_monitor.sv
// Concurrent checks on the ports of the serial configuration loader
`timescale 1ns/1ps
module scl_loader_monitor (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic MODE_SEL_HI,
  input wire logic MODE_SEL_MID,
  input wire logic MODE_SEL_LO,
  input wire logic RESTART,
  input wire logic INIT_I,
  input wire logic INIT_OE,
  input wire logic CONFIG_CLOCK_O,
  input wire logic CONFIG_CLOCK_OE,
  input wire logic DONE,
  input wire logic PULLUP_EN,
  input wire logic TAP_CONFIG_EN,
  input wire logic SERIAL_LOAD_EN,
  input wire logic BYTE_PARALLEL_EN
);
  logic [2:0] mode;
  assign mode = {MODE_SEL_HI, MODE_SEL_MID, MODE_SEL_LO};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_clear_hold; $rose(RESTART) |-> INIT_OE [*8]; endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("init released too soon after restart");
  property p_wait_init; (!SERIAL_LOAD_EN && !INIT_I) [*3] |=> !SERIAL_LOAD_EN; endproperty
  a_wait_init: assert property (p_wait_init)
    else $error("loading began while init held low");
  property p_restart_reset; (!RESTART) [*5] |-> INIT_OE && !DONE; endproperty
  a_restart_reset: assert property (p_restart_reset)
    else $error("restart low did not hold the loader in reset");
  property p_clock_dir;
    ($stable(mode) && !RESTART) [*6] |-> CONFIG_CLOCK_OE == (mode[1:0] == 2'h0);
  endproperty
  a_clock_dir: assert property (p_clock_dir)
    else $error("clock direction does not match mode");
  property p_pullup; ($stable(mode) && !RESTART) [*6] |-> PULLUP_EN == !mode[2]; endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up enable does not match top mode bit");
  property p_excl; SERIAL_LOAD_EN |-> !BYTE_PARALLEL_EN && TAP_CONFIG_EN; endproperty
  a_excl: assert property (p_excl)
    else $error("load paths enabled together");
  property p_done_ok; $rose(DONE) |-> $past(SERIAL_LOAD_EN) && !INIT_OE; endproperty
  a_done_ok: assert property (p_done_ok)
    else $error("complete raised without a good load");
  property p_err; (INIT_OE && SERIAL_LOAD_EN) [*2] |-> !DONE; endproperty
  a_err: assert property (p_err)
    else $error("complete high after a check error");
  property p_clk_half; $rose(CONFIG_CLOCK_O) |-> ##[1:2] !CONFIG_CLOCK_O; endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("master clock high phase too long");
  c_done: cover property ($rose(DONE));
  c_err: cover property (INIT_OE && SERIAL_LOAD_EN);
  c_fast: cover property ($rose(CONFIG_CLOCK_O) ##1 !CONFIG_CLOCK_O);
endmodule

bind scl_loader scl_loader_monitor i_scl_loader_monitor (.CLK_SYS, .RSTN, .MODE_SEL_HI,
  .MODE_SEL_MID, .MODE_SEL_LO, .RESTART, .INIT_I, .INIT_OE, .CONFIG_CLOCK_O, .CONFIG_CLOCK_OE,
  .DONE, .PULLUP_EN, .TAP_CONFIG_EN, .SERIAL_LOAD_EN, .BYTE_PARALLEL_EN);

// file: test/scl_prom_model.sv
// Serial configuration source feeding the loader's data input
`timescale 1ns/1ps
module scl_prom_model (
  input  wire logic        config_clock,
  input  wire logic        init,
  input  wire logic        stop,
  input  wire logic [95:0] image,
  output logic             din
);
  logic [95:0] sr;
  logic [6:0]  left;
  always @(negedge config_clock or negedge init) begin
    if (!init) begin // Held in reset while init is low
      sr <= image;
      left <= 7'h60;
    end else if (left != 7'h00 && !stop) begin // New bit after the fall
      sr <= {sr[94:0], ~sr[95]};
      left <= left - 7'h01;
    end else begin // Released line toggles
      sr[95] <= ~sr[95];
    end
  end
  assign din = sr[95];
endmodule

// file: test/scl_loader_tb.sv
// Self-checking testbench for the serial configuration loader
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module scl_loader_tb;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        restart = 1'b0;
  logic        ext_hold = 1'b0;
  logic        tb_config_clock = 1'b0;
  logic [2:0]  mode = 3'h7;
  logic [95:0] img = '1;
  logic        init_o, init_oe, cco, cco_oe, dout, done, pull_en, mpu, tap_en, load_en, byte_en;
  logic        din;
  wire         init_pad = (init_oe ? init_o : 1'b1) & ~ext_hold;
  wire         config_clock_pad = cco_oe ? cco : tb_config_clock;
  wire [4:0]   mode_outs = {cco_oe, load_en, byte_en, pull_en, tap_en};
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #50 clk_sys = ~clk_sys;

  scl_loader #(.BIT_TOTAL(64), .CLEAR_CYC(16), .FINAL_CYC(2)) i_scl_loader (
    .CLK_SYS(clk_sys), .RSTN(rstn), .MODE_SEL_HI(mode[2]), .MODE_SEL_MID(mode[1]),
    .MODE_SEL_LO(mode[0]), .RESTART(restart), .INIT_I(init_pad), .INIT_O(init_o),
    .INIT_OE(init_oe), .CONFIG_CLOCK_I(config_clock_pad), .CONFIG_CLOCK_O(cco),
    .CONFIG_CLOCK_OE(cco_oe), .SERIAL_DIN(din), .SERIAL_DOUT(dout), .DONE(done),
    .PULLUP_EN(pull_en), .MODE_PIN_PULLUP(mpu), .TAP_CONFIG_EN(tap_en),
    .SERIAL_LOAD_EN(load_en), .BYTE_PARALLEL_EN(byte_en));

  scl_prom_model i_scl_prom_model (.config_clock(config_clock_pad), .init(init_pad), .stop(cco_oe & done),
    .image(img), .din(din));

  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function logic sel(input int w);
    return (w == 0) ? init_oe : (w == 1) ? load_en : done;
  endfunction

  task wait_on(input int w, input logic v);
    for (int i = 0; i < 3000 && sel(w) !== v; i++) @(negedge clk_sys);
    if (sel(w) !== v) begin
      n_mismatch++;
      end_of_test;
    end
  endtask

  function logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  // Idle ones, sync word, rate, filler, check word, then bits for the next device
  function logic [95:0] mk(input logic [7:0] rate, input logic bad);
    return {16'hffff, 32'h5a3cc3a5, rate, 8'h5c, crc16({rate, 8'h5c}) ^ {15'h0, bad}, 16'h6c93};
  endfunction

  task start_cfg(input logic [2:0] m);
    mode = m;
    restart = 1'b0;
    repeat (6) @(negedge clk_sys);
    // Unless the mode is master, clock the link while loading is off so stale link state is cleared
    repeat (4) begin
      #80 tb_config_clock = 1'b1;
      #80 tb_config_clock = 1'b0;
    end
    @(negedge clk_sys);
    restart = 1'b1;
  endtask

  task slave_clk(input logic chk);
    for (int j = 0; j < 96; j++) begin
      #80 tb_config_clock = 1'b1;
      #80 tb_config_clock = 1'b0;
      if (chk && j == 78) `CHK(done, 1'b0)
      if (chk && j >= 2) `CHK(dout, (j >= 80) ? img[95 - j] : 1'b1)
    end
  endtask

  task t_modes;
    logic [4:0] exp_outs;
    for (int c = 0; c < 8; c++) begin
      start_cfg(c[2:0]);
      wait_on(0, 1'b0);
      repeat (8) @(negedge clk_sys);
      exp_outs = {c[1:0] == 2'h0, c[1] == c[0], c[1:0] == 2'h2, !c[2], 1'b1};
      `CHK(mode_outs, exp_outs)
    end
  endtask

  task t_slave;
    img = mk(8'h00, 1'b0);
    ext_hold = 1'b1;
    start_cfg(3'h7);
    wait_on(0, 1'b0);
    repeat (20) @(negedge clk_sys);
    `CHK(load_en, 1'b0)
    ext_hold = 1'b0;
    wait_on(1, 1'b1);
    `CHK({cco_oe, pull_en}, 2'h0)
    slave_clk(1'b1);
    repeat (6) @(negedge clk_sys);
    `CHK({done, init_oe, pull_en}, 3'h4)
  endtask

  task t_crc_err;
    img = mk(8'h00, 1'b1);
    start_cfg(3'h3);
    wait_on(1, 1'b1);
    `CHK(pull_en, 1'b1)
    slave_clk(1'b0);
    repeat (6) @(negedge clk_sys);
    `CHK({done, init_oe}, 2'h1)
  endtask

  task t_master(input logic [2:0] m, input logic [7:0] rate, input int half);
    int hw, first, last;
    hw = 0;
    first = 0;
    last = 0;
    img = mk(rate, 1'b0);
    start_cfg(m);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(negedge clk_sys);
      if (cco === 1'b1) hw++;
      else begin
        if (hw > 0 && first == 0) first = hw;
        if (hw > 0) last = hw;
        hw = 0;
      end
    end
    `CHK({done, cco_oe}, 2'h3)
    `CHK(first[3:0], 4'h2)
    `CHK(last[3:0], half[3:0])
    if (done !== 1'b1) end_of_test;
  endtask

  initial begin
    #2ms;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    `CHK({init_o, mpu}, 2'h1)
    t_modes;
    t_slave;
    t_crc_err;
    t_master(3'h0, 8'h00, 2);
    t_master(3'h4, 8'h01, 2);
    t_master(3'h0, 8'h64, 1);
    end_of_test;
  end
endmodule
